// >>> design/pcei_pkg.sv
package pcei_pkg;

    // ==========================================================
    // Register map (byte addresses, one aligned word each)
    localparam logic [3:0] RISE_EN_OFS   = 4'h0;   // rise_edge_enable
    localparam logic [3:0] FALL_EN_OFS   = 4'h4;   // fall_edge_enable
    localparam logic [3:0] FLAGS_OFS     = 4'h8;   // pin_change_flags
    localparam logic [3:0] INT_CTRL_OFS  = 4'hC;   // interrupt_control

    // ==========================================================
    // Field positions inside interrupt_control
    localparam int MASTER_EN_BIT  = 3;              // change_int_master_enable
    localparam int SUMMARY_BIT    = 0;              // change_int_summary_flag

    // ==========================================================
    // Reset values and widths
    localparam int          PIN_COUNT   = 8;
    localparam logic [7:0]  EN_RESET    = 8'h00;
    localparam logic [7:0]  FLAG_RESET  = 8'h00;
    localparam logic        MEN_RESET   = 1'h0;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // ==========================================================
    // Bus answer state
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,   // Waiting for a request
        BUS_ACK  = 2'b01    // Answering in this cycle
    } pcei_bus_e;

    // Avalon request carrier
    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } pcei_req_s;

endpackage

// >>> design/pcei_top.sv
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
module pcei_top
    import pcei_pkg::*;
(
    input  wire logic        ref_clk,            // System clock, 250 MHz
    input  wire logic        nrst,               // Synchronous reset, active low
    input  wire logic        clkEn,              // Freezes all state while low
    input  wire logic [7:0]  inputPortPin,       // Asynchronous port pins
    input  wire logic [3:0]  avs_address,        // Byte address
    input  wire logic        avs_read,           // Read strobe
    input  wire logic        avs_write,          // Write strobe
    input  wire logic [31:0] avs_writedata,      // Write data
    input  wire logic [3:0]  avs_byteenable,     // Byte lanes
    output logic [31:0]      avs_readdata,       // Read data
    output logic             avs_waitrequest,    // Low on the answering cycle
    output logic             changeIrq,          // Interrupt request level
    output logic             wakeReq             // Wake from sleep pulse
);

    // ==========================================================
    // Storage
    logic [7:0]  riseEn_reg;        // rise_edge_enable
    logic [7:0]  fallEn_reg;        // fall_edge_enable
    logic [7:0]  flags_reg;         // pin_change_flags
    logic        masterEn_reg;      // change_int_master_enable
    logic [7:0]  sync1_reg;         // First synchroniser stage
    logic [7:0]  sync2_reg;         // Second stage
    logic [7:0]  sync3_reg;         // Third stage
    logic [7:0]  pinState_reg;      // Accepted pin level
    pcei_bus_e   busState_reg;      // Bus answer state
    pcei_req_s   req;               // Bundled request
    logic [7:0]  pinNext;           // Next accepted level
    logic [7:0]  riseHit;           // Enabled rising edges
    logic [7:0]  fallHit;           // Enabled falling edges
    logic [7:0]  edgeHit;           // Any enabled edge
    logic [7:0]  flags_next;        // Next flag value
    logic        summary;           // OR of all next flag values
    logic        accept;            // Request taken this cycle
    logic        wrFlags;           // Write hits the flag register
    logic        lane0;             // Low byte lane enabled
    logic [31:0] ctrlRd;            // Control word as software reads it

    assign req     = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata};
    assign accept  = clkEn && (busState_reg == BUS_IDLE) && (req.read || req.write);
    assign lane0   = avs_byteenable[0];

    // Write decode for one register, low lane only
    function automatic logic hitWr(input pcei_req_s r, input logic [3:0] ofs, input logic ln);
        hitWr = r.write && ln && (r.address == ofs);
    endfunction

    // ==========================================================
    // Pin input synchroniser, three stages
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            // All stages start at the low level
            sync1_reg <= 8'h00;
            sync2_reg <= 8'h00;
            sync3_reg <= 8'h00;
        end else if (clkEn) begin
            // Shift the pins one stage further in
            sync1_reg <= inputPortPin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A pin level is accepted once stages two and three agree
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            pinNext[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pinState_reg[i];
        end
    end

    // Previous accepted level for edge comparison
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pinState_reg <= 8'h00;
        end else if (clkEn) begin
            pinState_reg <= pinNext;
        end
    end

    // ==========================================================
    // Edge detection, each transition seen once
    assign riseHit = pinNext & ~pinState_reg & riseEn_reg;
    assign fallHit = ~pinNext & pinState_reg & fallEn_reg;
    assign edgeHit = riseHit | fallHit;

    // ==========================================================
    // Flag update: write clears, hardware set wins
    assign wrFlags = accept && hitWr(req, FLAGS_OFS, lane0);

    always_comb begin
        flags_next = flags_reg;
        if (wrFlags) begin
            // Bits written as zero are cleared, ones keep their value
            flags_next = flags_reg & req.writedata[7:0];
        end
        // An edge in this cycle sets its bit last, so it beats the clear
        flags_next = flags_next | edgeHit;
    end

    // Flag register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            flags_reg <= FLAG_RESET;
        end else if (clkEn) begin
            flags_reg <= flags_next;
        end
    end

    // ==========================================================
    // Enable registers, written over the bus
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            riseEn_reg   <= EN_RESET;
            fallEn_reg   <= EN_RESET;
            masterEn_reg <= MEN_RESET;
        end else if (accept) begin
            // Only a write on the low byte lane reaches these registers
            if (hitWr(req, RISE_EN_OFS, lane0)) begin
                riseEn_reg <= req.writedata[7:0];
            end else if (hitWr(req, FALL_EN_OFS, lane0)) begin
                fallEn_reg <= req.writedata[7:0];
            end else if (hitWr(req, INT_CTRL_OFS, lane0)) begin
                masterEn_reg <= req.writedata[MASTER_EN_BIT];
            end
        end
    end

    // ==========================================================
    // Interrupt and wake outputs
    assign summary = |flags_next;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            // No request and no wake out of reset
            changeIrq <= 1'b0;
            wakeReq   <= 1'b0;
        end else if (clkEn) begin
            changeIrq <= summary && masterEn_reg;
            // Wake rises together with the flag it reports
            wakeReq   <= masterEn_reg && (|edgeHit);
        end
    end

    // ==========================================================
    // Avalon slave: one wait cycle, answer on the next
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            busState_reg    <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (clkEn) begin
            case (busState_reg)
                BUS_IDLE: begin
                    // Take a request as soon as one is presented
                    if (accept) begin
                        busState_reg    <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                default: begin
                    // Answer given, back to waiting
                    busState_reg    <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Control word: master enable and summary at their own positions
    always_comb begin
        ctrlRd                = UNMAPPED_RD;     // Unused bits read zero
        ctrlRd[MASTER_EN_BIT] = masterEn_reg;    // change_int_master_enable
        ctrlRd[SUMMARY_BIT]   = |flags_reg;
    end

    // Read data captured when the request is taken
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            avs_readdata <= UNMAPPED_RD;
        end else if (accept) begin
            if (!req.read) begin
                // A write leaves zero on the read bus
                avs_readdata <= UNMAPPED_RD;
            end else if (req.address == RISE_EN_OFS) begin
                avs_readdata <= {24'h000000, riseEn_reg};
            end else if (req.address == FALL_EN_OFS) begin
                avs_readdata <= {24'h000000, fallEn_reg};
            end else if (req.address == FLAGS_OFS) begin
                avs_readdata <= {24'h000000, flags_reg};
            end else if (req.address == INT_CTRL_OFS) begin
                avs_readdata <= ctrlRd;
            end else begin
                avs_readdata <= UNMAPPED_RD;
            end
        end
    end

    // ==========================================================
    // Checks
    // Each label carries the rule it guards; covers follow at the end

    // Edge detection and the rise enable write
    // A rising edge on pin 0 with its enable sets the flag
    riseSet_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && riseHit[0] |=> flags_reg[0])
        else $error("rise edge did not set flag");
    // A falling edge on pin 7 with its enable sets the flag
    fallSet_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && fallHit[7] |=> flags_reg[7])
        else $error("fall edge did not set flag");
    // With both enables clear, pin 4 never raises its flag
    noEnable_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && !riseEn_reg[4] && !fallEn_reg[4] && !flags_reg[4] |=> !flags_reg[4])
        else $error("flag set with edges disabled");
    // A clear flag stays clear without an edge
    noArm_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && !flags_reg[1] && !edgeHit[1] |=> !flags_reg[1])
        else $error("flag set without edge");
    // A rise enable write lands as written
    riseWrite_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        accept && hitWr(req, RISE_EN_OFS, lane0) |=> riseEn_reg == 8'($past(avs_writedata)))
        else $error("rise enable write lost");

    // Flag register
    // An edge during a flag write keeps the flag set
    clearWin_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        wrFlags && edgeHit[2] |=> flags_reg[2])
        else $error("edge lost during clear");
    // A zero written to a flag clears it
    clearZero_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        wrFlags && !req.writedata[3] && !edgeHit[3] |=> !flags_reg[3])
        else $error("zero write did not clear");
    // Clock enable low freezes the flags and the enables
    freezeHold_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        !clkEn |=> $stable(flags_reg) && $stable(riseEn_reg) && $stable(fallEn_reg))
        else $error("state moved while frozen");

    // Interrupt and wake
    // A request follows a master enable that was set
    irqGate_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        changeIrq |-> $past(masterEn_reg))
        else $error("irq without master enable");
    // Master enable clear holds the request low
    irqOff_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && !masterEn_reg |=> !changeIrq)
        else $error("irq while master disabled");
    // Any flag with the master enable raises the request
    irqSum_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && masterEn_reg && (|flags_reg) && !wrFlags |=> changeIrq)
        else $error("irq missing");
    // The summary bit reads as the OR of the flags
    summaryRd_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        accept && req.read && req.address == INT_CTRL_OFS |=> avs_readdata[SUMMARY_BIT] == ($past(flags_reg) != 8'h00))
        else $error("summary bit wrong");
    // Wake never comes ahead of its flag
    wakeFlag_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        wakeReq |-> (|flags_reg))
        else $error("wake before flag update");
    // An enabled edge with the master enable wakes
    wakeCause_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && masterEn_reg && (|edgeHit) |=> wakeReq)
        else $error("no wake on edge");
    // No wake while the master enable is clear
    wakeGate_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        clkEn && !masterEn_reg |=> !wakeReq)
        else $error("wake while master disabled");

    // Bus and reset
    // One wait cycle, one answer cycle
    busAns_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        accept |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer timing wrong");
    // Waitrequest stands high while no answer is due
    idleWait_a : assert property (@(posedge ref_clk) disable iff (!nrst)
        busState_reg == BUS_IDLE |-> avs_waitrequest)
        else $error("waitrequest low while idle");
    // Reset clears the enables and the flags
    resetClear_a : assert property (@(posedge ref_clk)
        !nrst |=> flags_reg == FLAG_RESET && riseEn_reg == EN_RESET && fallEn_reg == EN_RESET)
        else $error("registers not cleared by reset");

    // Main scenarios
    riseSeen_c  : cover property (@(posedge ref_clk) disable iff (!nrst) riseHit != 8'h00);
    bothSeen_c  : cover property (@(posedge ref_clk) disable iff (!nrst)
        (riseEn_reg & fallEn_reg) != 8'h00 && fallHit != 8'h00);
    clearRace_c : cover property (@(posedge ref_clk) disable iff (!nrst) wrFlags && edgeHit != 8'h00);
    irqRise_c   : cover property (@(posedge ref_clk) disable iff (!nrst) $rose(changeIrq));
    frozenPin_c : cover property (@(posedge ref_clk) disable iff (!nrst) !clkEn && sync1_reg != inputPortPin);

endmodule

// >>> sim/pcei_pin_model.sv
// ==========================================================
// Model of the external input pins
module pcei_pin_model
    import pcei_pkg::*;
(
    input  wire logic [7:0] pinLevel,       // Level the bench wants on each pin
    output logic      [7:0] inputPortPin    // Pins as the block sees them
);
    timeunit 1ns;
    timeprecision 100ps;

    // Pins are always driven by their source, so no released state exists
    assign inputPortPin = pinLevel;
endmodule

// >>> sim/pin_change_edge_interrupt_bench.sv
// Compares one value, counts it and reports a mismatch
`define CHK(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", what, exp, got); end end

module pin_change_edge_interrupt_bench;
    import pcei_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk, nrst, avs_read, avs_write, changeIrq, wakeReq, avs_waitrequest;
    logic [7:0]  pinLevel, inputPortPin, expFlags, riseEn, fallEn, pinNow;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        masterOn;                  // Master enable as software set it
    logic        clkEn;                     // Clock enable, lowered once to freeze the block
    logic [7:0]  expQ[$];                   // Expected read data, oldest first
    int          mismatches, tests_run, wakeSeen, wakeExp;

    pcei_pin_model pins (.pinLevel(pinLevel), .inputPortPin(inputPortPin));

    pcei_top DUT (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .inputPortPin(inputPortPin),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .changeIrq(changeIrq), .wakeReq(wakeReq));

    // ==========================================================
    // Clock, read checker and wake pulse counter
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            `CHK("read data", {24'h0, expQ.pop_front()}, avs_readdata)
        end
        if (wakeReq === 1'b1) begin
            wakeSeen++;
        end
    end

    // ==========================================================
    // Bus and pin tasks
    task automatic bus_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be = 4'hF);
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic bus_read(input logic [3:0] a, input logic [7:0] e);
        expQ.push_back(e);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Moves the pins and notes which flags the move must set
    task automatic pin_step(input logic [7:0] n);
        logic [7:0] hit;
        hit = (riseEn & ~pinNow & n) | (fallEn & pinNow & ~n);
        expFlags = expFlags | hit;
        if (masterOn && hit != 8'h00) wakeExp++;
        pinLevel <= n;
        pinNow = n;
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        wrap_up();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(96571));
        {nrst, avs_read, avs_write, masterOn} = 4'h0;
        clkEn = 1'b1;
        {pinLevel, pinNow, expFlags} = 24'h0;
        {avs_address, avs_byteenable, avs_writedata} = 40'h0;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        bus_read(RISE_EN_OFS, 8'h00);
        bus_read(FALL_EN_OFS, 8'h00);
        bus_read(INT_CTRL_OFS, 8'h00);
        bus_read(4'h2, 8'h00);
        // Rise only, fall only, both, then random enables, master off
        for (int r = 0; r < 4; r++) begin
            riseEn = (r == 1) ? 8'h00 : (r == 3) ? 8'($urandom) : 8'hFF;
            fallEn = (r == 0) ? 8'h00 : (r == 3) ? 8'($urandom) : 8'hFF;
            bus_write(RISE_EN_OFS, riseEn);
            bus_write(FALL_EN_OFS, fallEn);
            bus_read(FALL_EN_OFS, fallEn);
            for (int i = 0; i < 6; i++) pin_step(8'($urandom));
            bus_read(FLAGS_OFS, expFlags);
            `CHK("request while master off", 1'b0, changeIrq)
            bus_write(FLAGS_OFS, 8'hFF ^ expFlags);
            expFlags = 8'h00;
            bus_read(FLAGS_OFS, 8'h00);
        end
        // Master on: summary, request and wake
        bus_write(INT_CTRL_OFS, 8'h08);
        masterOn = 1'b1;
        bus_write(RISE_EN_OFS, 8'hFF);
        bus_write(FALL_EN_OFS, 8'hFF);
        {riseEn, fallEn} = 16'hFFFF;
        pin_step(~pinNow);
        bus_read(INT_CTRL_OFS, 8'h09);
        `CHK("request with master on", 1'b1, changeIrq)
        bus_write(FLAGS_OFS, 8'h00, 4'hE);
        bus_read(FLAGS_OFS, 8'hFF);
        // Edge lands on the same edge as a clearing write
        bus_write(FLAGS_OFS, 8'h00);
        pinLevel <= pinNow ^ 8'h04;
        pinNow = pinNow ^ 8'h04;
        wakeExp++;
        // Three edges carry the new level through; the write is taken on the fourth
        repeat (3) @(posedge ref_clk);
        bus_write(FLAGS_OFS, 8'h00);
        repeat (4) @(posedge ref_clk);
        bus_read(FLAGS_OFS, 8'h04);
        bus_write(FLAGS_OFS, 8'hFB);
        `CHK("request after clear", 1'b0, changeIrq)
        // Clock enable low: a pin edge waits until the clock runs again
        clkEn    <= 1'b0;
        pinLevel <= pinNow ^ 8'h10;
        pinNow   = pinNow ^ 8'h10;
        repeat (6) @(posedge ref_clk);
        `CHK("wake while frozen", wakeExp, wakeSeen)
        `CHK("request while frozen", 1'b0, changeIrq)
        clkEn <= 1'b1;
        wakeExp++;
        repeat (6) @(posedge ref_clk);
        bus_read(FLAGS_OFS, 8'h10);
        `CHK("wake pulses", wakeExp, wakeSeen)
        // Reset in mid-run clears everything again
        nrst <= 1'b0;
        @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        bus_read(RISE_EN_OFS, 8'h00);
        bus_read(FLAGS_OFS, 8'h00);
        wrap_up();
    end
endmodule
